// *** verilog/uoec_top.sv ***
// OUT endpoint control: register file, handshake decision and interrupt
//
// Chosen here: the Avalon-MM interface to the registers.
module uoec_top (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Avalon-MM slave
    input wire logic [uoec_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [uoec_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [uoec_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    // Link side, from the packet receiver
    input wire logic rxPacketDone,
    input wire logic [uoec_pkg::CNT_W-1:0] rxByteCount,
    input wire logic rxCrcError,
    // Link side, to the handshake sender and data buffer
    output logic hsValid,
    output uoec_pkg::uoec_hs_t hsCode,
    output logic dataToggle,
    output logic pktAccept,
    // Interrupt
    output logic irq
);

    // ***************************************************************
    // Declarations
    // ***************************************************************
    uoec_slot_if slots ();

    logic busReq;
    logic access;
    logic aligned;
    logic [uoec_pkg::IDX_W-1:0] regIdx;
    logic [uoec_pkg::REG_W-1:0] wd;
    logic wrEn;
    logic wrLo;
    logic wrHi;
    logic wrStat;
    logic wrMask;
    logic [uoec_pkg::REG_W-1:0] rdByte;

    logic stallRequest;
    logic doubleBufferEnable;
    logic isoMode;
    logic packetReady;
    logic stallSentFlag;
    logic packetLostFlag;
    logic packetErrorFlag;
    logic flushPend;
    logic [uoec_pkg::INT_W-1:0] intStatus;
    logic [uoec_pkg::INT_W-1:0] intMask;

    logic bufferFullStatus;
    logic stallActive;
    logic swClear;
    logic popNow;
    logic readyRise;
    logic hasPacket;
    uoec_pkg::uoec_hs_t next_hs;
    logic doPush;
    logic stallEv;
    logic lostEv;
    logic errEv;
    logic [uoec_pkg::INT_W-1:0] intEv;
    logic [uoec_pkg::INT_W-1:0] intClr;

    // ***************************************************************
    // Packet slot store
    // ***************************************************************
    uoec_slot_store u_store (
        .sys_clk(sys_clk),
        .rst(rst),
        .bus(slots.store)
    );

    // ***************************************************************
    // Bus decode
    // ***************************************************************
    // Only byte lane 0 carries register data; other lanes are ignored
    assign busReq = avs_read | avs_write;
    assign access = busReq & ~avs_waitrequest;
    assign aligned = (avs_address[1:0] == 2'b00);
    assign regIdx = avs_address[uoec_pkg::ADDR_W-1:2];
    assign wd = avs_writedata[uoec_pkg::REG_W-1:0];
    assign wrEn = avs_write & access & avs_byteenable[0] & aligned;
    assign wrLo = wrEn & (regIdx == uoec_pkg::IDX_CTRL_LO);
    assign wrHi = wrEn & (regIdx == uoec_pkg::IDX_CTRL_HI);
    assign wrStat = wrEn & (regIdx == uoec_pkg::IDX_INT_STAT);
    assign wrMask = wrEn & (regIdx == uoec_pkg::IDX_INT_MASK);

    // Every request sees exactly one wait cycle, then completes
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= ~(busReq & avs_waitrequest);
        end
    end

    // Read data captured during the wait cycle, stable at completion
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            avs_readdata <= '0;
        end else if (avs_read && avs_waitrequest) begin
            avs_readdata <= {{(uoec_pkg::DATA_W - uoec_pkg::REG_W){1'b0}}, rdByte};
        end
    end

    // ***************************************************************
    // Read multiplexer
    // ***************************************************************
    // Unmapped and misaligned reads return zero
    always_comb begin
        rdByte = uoec_pkg::RST_REG;
        if (aligned) begin
            case (regIdx)
                uoec_pkg::IDX_CTRL_LO: begin
                    rdByte[uoec_pkg::BIT_TOGGLE_CLEAR] = 1'b0; // [R1]
                    rdByte[uoec_pkg::BIT_STALL_SENT] = stallSentFlag;
                    rdByte[uoec_pkg::BIT_STALL_REQ] = stallRequest;
                    rdByte[uoec_pkg::BIT_FLUSH] = flushPend;
                    rdByte[uoec_pkg::BIT_PKT_ERR] = packetErrorFlag;
                    rdByte[uoec_pkg::BIT_PKT_LOST] = packetLostFlag;
                    rdByte[uoec_pkg::BIT_FULL] = bufferFullStatus; // [R7]
                    rdByte[uoec_pkg::BIT_READY] = packetReady;
                end
                uoec_pkg::IDX_CTRL_HI: begin
                    // Unused bits stay at zero [R12]
                    rdByte[uoec_pkg::BIT_DBL_EN] = doubleBufferEnable;
                    rdByte[uoec_pkg::BIT_ISO] = isoMode;
                end
                uoec_pkg::IDX_CNT_LO: begin
                    rdByte = slots.headCount[uoec_pkg::CNT_LO_W-1:0]; // [R11]
                end
                uoec_pkg::IDX_CNT_HI: begin
                    // Upper count bits in bits 1-0, rest zero [R11] [R12]
                    rdByte[uoec_pkg::CNT_W-uoec_pkg::CNT_LO_W-1:0] =
                        slots.headCount[uoec_pkg::CNT_W-1:uoec_pkg::CNT_LO_W];
                end
                uoec_pkg::IDX_INT_STAT: begin
                    rdByte[uoec_pkg::INT_W-1:0] = intStatus;
                end
                uoec_pkg::IDX_INT_MASK: begin
                    rdByte[uoec_pkg::INT_W-1:0] = intMask;
                end
                default: begin
                    rdByte = uoec_pkg::RST_REG;
                end
            endcase
        end
    end

    // ***************************************************************
    // Configuration
    // ***************************************************************
    // Only the two defined bits of control-high are stored [R12]
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            doubleBufferEnable <= 1'b0;
            isoMode <= 1'b0;
        end else if (wrHi) begin
            doubleBufferEnable <= wd[uoec_pkg::BIT_DBL_EN]; // [R9]
            isoMode <= wd[uoec_pkg::BIT_ISO]; // [R10]
        end
    end

    // Stall request level, held until software writes zero
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stallRequest <= 1'b0;
        end else if (wrLo) begin
            stallRequest <= wd[uoec_pkg::BIT_STALL_REQ]; // [R3]
        end
    end

    // ***************************************************************
    // Occupancy and stall qualification
    // ***************************************************************
    // Full threshold follows the double-buffer setting [R7] [R9]
    assign bufferFullStatus = doubleBufferEnable ?
        (slots.level == uoec_pkg::DEPTH_DBL) :
        (slots.level >= uoec_pkg::DEPTH_SGL);
    assign hasPacket = (slots.level != uoec_pkg::LEVEL_EMPTY);

    // Stalling has no meaning for isochronous pipes [R3]
    assign stallActive = stallRequest & ~isoMode;

    // ***************************************************************
    // Handshake decision per received OUT data packet
    // ***************************************************************
    // Unless stalled, a corrupt bulk packet gets no handshake so the host retries it
    always_comb begin
        next_hs = uoec_pkg::HS_NONE;
        doPush = 1'b0;
        stallEv = 1'b0;
        lostEv = 1'b0;
        if (rxPacketDone) begin
            if (isoMode) begin
                if (bufferFullStatus) begin
                    lostEv = 1'b1; // [R6]
                end else begin
                    doPush = 1'b1; // [R15]
                end
            end else if (stallActive) begin
                next_hs = uoec_pkg::HS_STALL; // [R13]
                stallEv = 1'b1;
            end else if (rxCrcError) begin
                next_hs = uoec_pkg::HS_NONE;
            end else if (bufferFullStatus) begin
                next_hs = uoec_pkg::HS_NAK; // [R16]
            end else begin
                next_hs = uoec_pkg::HS_ACK;
                doPush = 1'b1;
            end
        end
    end

    assign errEv = doPush & isoMode & rxCrcError; // [R5]

    // ***************************************************************
    // Slot store control
    // ***************************************************************
    // Software clearing packet_ready releases the head packet [R8]
    assign swClear = wrLo & ~wd[uoec_pkg::BIT_READY] & packetReady;
    assign popNow = swClear | flushPend; // [R4]
    assign slots.push = doPush;
    assign slots.pushCount = rxByteCount; // [R11]
    assign slots.pop = popNow;

    // ***************************************************************
    // Link outputs
    // ***************************************************************
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hsValid <= 1'b0;
            hsCode <= uoec_pkg::HS_NONE;
            pktAccept <= 1'b0;
        end else begin
            hsValid <= (next_hs != uoec_pkg::HS_NONE);
            hsCode <= next_hs;
            pktAccept <= doPush;
        end
    end

    // Data toggle flips on each accepted bulk packet
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dataToggle <= 1'b0;
        end else if (wrLo && wd[uoec_pkg::BIT_TOGGLE_CLEAR]) begin
            dataToggle <= 1'b0; // [R1]
        end else if (doPush && !isoMode) begin
            dataToggle <= ~dataToggle;
        end
    end

    // ***************************************************************
    // Packet ready and flush
    // ***************************************************************
    // Re-asserts one cycle after a clear when a second packet waits
    assign readyRise = ~packetReady & hasPacket & ~popNow;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            packetReady <= 1'b0;
        end else if (popNow) begin
            packetReady <= 1'b0; // [R4] [R8]
        end else if (hasPacket) begin
            packetReady <= 1'b1; // [R8] [R14]
        end
    end

    // Flush lives one cycle: set by the write, done at the next edge
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            flushPend <= 1'b0;
        end else begin
            flushPend <= wrLo & wd[uoec_pkg::BIT_FLUSH]; // [R4]
        end
    end

    // ***************************************************************
    // Sticky endpoint flags, a new event wins over a clear
    // ***************************************************************
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stallSentFlag <= 1'b0;
        end else if (stallEv) begin
            stallSentFlag <= 1'b1; // [R2] [R13]
        end else if (wrLo && !wd[uoec_pkg::BIT_STALL_SENT]) begin
            stallSentFlag <= 1'b0; // [R2]
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            packetLostFlag <= 1'b0;
        end else if (lostEv) begin
            packetLostFlag <= 1'b1; // [R6]
        end else if (wrLo && !wd[uoec_pkg::BIT_PKT_LOST]) begin
            packetLostFlag <= 1'b0;
        end
    end

    // Error belongs to the packet being unloaded, so it goes with ready
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            packetErrorFlag <= 1'b0;
        end else if (errEv) begin
            packetErrorFlag <= 1'b1; // [R5]
        end else if (swClear) begin
            packetErrorFlag <= 1'b0; // [R5]
        end
    end

    // ***************************************************************
    // Interrupt status, mask and output
    // ***************************************************************
    always_comb begin
        intEv = uoec_pkg::RST_INT;
        intEv[uoec_pkg::INT_READY] = readyRise; // [R8] [R14] [R15]
        intEv[uoec_pkg::INT_STALL] = stallEv; // [R13]
        intEv[uoec_pkg::INT_LOST] = lostEv; // [R6]
    end

    assign intClr = wrStat ? wd[uoec_pkg::INT_W-1:0] : uoec_pkg::RST_INT;

    // Write one to clear; a simultaneous event keeps the bit set
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            intStatus <= uoec_pkg::RST_INT;
        end else begin
            intStatus <= (intStatus & ~intClr) | intEv;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            intMask <= uoec_pkg::RST_INT;
        end else if (wrMask) begin
            intMask <= wd[uoec_pkg::INT_W-1:0];
        end
    end

    // Registered, so it trails the status bit by one cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(intStatus & intMask);
        end
    end

endmodule : uoec_top

// *** verilog/uoec_pkg.sv ***
// Constants and types shared by the OUT endpoint control block
// What this block does
// [R1] Writing one to toggle_clear zeroes the data toggle; the bit reads zero.
// [R2] stall_sent_flag sets on each STALL sent and holds until software writes zero.
// [R3] stall_request makes the endpoint answer STALL; ignored in isochronous mode.
// [R4] Flush write drops the head packet, moves the pointer, clears packet_ready, self-clears.
// [R5] Isochronous CRC or stuffing error sets packet_error_flag; clearing packet_ready clears it.
// [R6] Isochronous packet lost to a full buffer sets packet_lost_flag; only software clears it.
// [R7] buffer_full_status reads one at two packets double-buffered, one packet otherwise.
// [R8] Available packet sets packet_ready and raises an interrupt; software clears it after unloading.
// [R9] double_buffer_enable selects two packet slots when set, one when clear.
// [R10] Transfer-type bit selects bulk or interrupt at zero, isochronous at one.
// [R11] Head packet byte count is ten bits, split over count-low and count-high bits 1-0.
// [R12] Unused bits of control-high and count-high read zero and ignore writes.
// [R13] Bulk with stall_request set answers every OUT with STALL, flag and interrupt.
// [R14] Second buffered packet sets packet_ready right after software clears it, new interrupt.
// [R15] Isochronous packet with CRC error is still stored, packet_ready set, interrupt raised.
// [R16] Bulk or interrupt with a full buffer answers NAK and keeps stored packets.
package uoec_pkg;

    // ***************************************************************
    // Bus geometry
    // ***************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    localparam int IDX_W = 6;

    // ***************************************************************
    // Register indexes, byte address is four times the index
    // ***************************************************************
    localparam logic [IDX_W-1:0] IDX_CTRL_LO = 6'h14;
    localparam logic [IDX_W-1:0] IDX_CTRL_HI = 6'h15;
    localparam logic [IDX_W-1:0] IDX_CNT_LO = 6'h16;
    localparam logic [IDX_W-1:0] IDX_CNT_HI = 6'h17;
    localparam logic [IDX_W-1:0] IDX_INT_STAT = 6'h18;
    localparam logic [IDX_W-1:0] IDX_INT_MASK = 6'h19;

    // ***************************************************************
    // Field positions
    // ***************************************************************
    localparam int BIT_TOGGLE_CLEAR = 7;
    localparam int BIT_STALL_SENT = 6;
    localparam int BIT_STALL_REQ = 5;
    localparam int BIT_FLUSH = 4;
    localparam int BIT_PKT_ERR = 3;
    localparam int BIT_PKT_LOST = 2;
    localparam int BIT_FULL = 1;
    localparam int BIT_READY = 0;
    localparam int BIT_DBL_EN = 7;
    localparam int BIT_ISO = 6;
    localparam int CNT_W = 10;
    localparam int CNT_LO_W = 8;

    // Interrupt status and mask layout
    localparam int INT_W = 3;
    localparam int INT_READY = 0;
    localparam int INT_STALL = 1;
    localparam int INT_LOST = 2;

    // ***************************************************************
    // Reset values and buffer depths
    // ***************************************************************
    localparam logic [REG_W-1:0] RST_REG = 8'h00;
    localparam logic [INT_W-1:0] RST_INT = 3'h0;
    localparam int SLOTS = 2;
    localparam logic [1:0] LEVEL_EMPTY = 2'h0;
    localparam logic [1:0] DEPTH_SGL = 2'h1;
    localparam logic [1:0] DEPTH_DBL = 2'h2;

    // Handshake answered to the host after an OUT data packet
    typedef enum logic [1:0] {
        HS_ACK = 2'b00,
        HS_NAK = 2'b01,
        HS_STALL = 2'b10,
        HS_NONE = 2'b11
    } uoec_hs_t;

endpackage : uoec_pkg

// *** verilog/uoec_slot_if.sv ***
// Interface between endpoint control and the packet slot store
interface uoec_slot_if;
    logic push;
    logic [uoec_pkg::CNT_W-1:0] pushCount;
    logic pop;
    logic [1:0] level;
    logic [uoec_pkg::CNT_W-1:0] headCount;

    // Control side issues push and pop, sees occupancy
    modport ctrl (output push, output pushCount, output pop, input level, input headCount);

    // Store side keeps the slots
    modport store (input push, input pushCount, input pop, output level, output headCount);
endinterface : uoec_slot_if

// *** verilog/uoec_slot_store.sv ***
// Two-slot packet store holding byte counts and read/write pointers
module uoec_slot_store (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Control side
    uoec_slot_if.store bus
);

    logic [uoec_pkg::CNT_W-1:0] counts [uoec_pkg::SLOTS];
    logic wrPtr;
    logic rdPtr;
    logic [1:0] level;

    // ***************************************************************
    // Slot storage, one register per slot
    // ***************************************************************
    for (genvar i = 0; i < uoec_pkg::SLOTS; i++) begin : g_slot
        always_ff @(posedge sys_clk or posedge rst) begin
            if (rst) begin
                counts[i] <= '0;
            end else if (bus.push && wrPtr == 1'(i)) begin
                counts[i] <= bus.pushCount;
            end
        end
    end

    // ***************************************************************
    // Pointers and occupancy
    // ***************************************************************
    // A pop on an empty store is ignored so a stray flush cannot wrap
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wrPtr <= 1'b0;
            rdPtr <= 1'b0;
            level <= uoec_pkg::LEVEL_EMPTY;
        end else begin
            if (bus.push) begin
                wrPtr <= ~wrPtr;
            end
            if (bus.pop && level != uoec_pkg::LEVEL_EMPTY) begin
                rdPtr <= ~rdPtr; // [R4]
            end
            case ({bus.push, bus.pop && level != uoec_pkg::LEVEL_EMPTY})
                2'b10: begin
                    level <= level + 2'h1;
                end
                2'b01: begin
                    level <= level - 2'h1;
                end
                default: begin
                    level <= level;
                end
            endcase
        end
    end

    assign bus.level = level;
    assign bus.headCount = counts[rdPtr];

endmodule : uoec_slot_store

// *** testbench/uoec_sva.sv ***
// Concurrent checks on the OUT endpoint control ports
module uoec_sva (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register bus
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Link side
    input wire logic rxPacketDone,
    input wire logic hsValid,
    input wire uoec_pkg::uoec_hs_t hsCode,
    input wire logic dataToggle,
    input wire logic pktAccept
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    // ***************************************************************
    // Handshake decision and register read-back
    // ***************************************************************
    a_hs_after_packet: assert property (hsValid |-> $past(rxPacketDone))
        else $error("handshake without a received packet");
    a_store_after_packet: assert property (pktAccept |-> $past(rxPacketDone))
        else $error("packet stored without a received packet");
    a_ack_stores: assert property (hsValid && hsCode == uoec_pkg::HS_ACK |-> pktAccept)
        else $error("acknowledged packet not stored");
    a_ack_flips_toggle: assert property (hsValid && hsCode == uoec_pkg::HS_ACK |-> $changed(dataToggle))
        else $error("data toggle did not flip on acknowledge");
    a_refusal_keeps_buffer: assert property (hsValid && hsCode inside {uoec_pkg::HS_NAK, uoec_pkg::HS_STALL}
        |-> !pktAccept && $stable(dataToggle)) else $error("refused packet changed the buffer");
    a_toggle_clear_zero: assert property (avs_write && !avs_waitrequest && avs_address == 8'h50
        && avs_byteenable[0] && avs_writedata[7] |=> !dataToggle) else $error("toggle not cleared");
    a_clear_reads_zero: assert property (avs_read && !avs_waitrequest && avs_address == 8'h50
        |-> !avs_readdata[7]) else $error("toggle clear bit read as one");
    a_ctrl_high_unused: assert property (avs_read && !avs_waitrequest && avs_address == 8'h54
        |-> avs_readdata[5:0] == 6'h00) else $error("unused control-high bits not zero");
    a_count_high_unused: assert property (avs_read && !avs_waitrequest && avs_address == 8'h5C
        |-> avs_readdata[7:2] == 6'h00) else $error("unused count-high bits not zero");
endmodule : uoec_sva

bind uoec_top uoec_sva i_sva (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rxPacketDone(rxPacketDone),
    .hsValid(hsValid), .hsCode(hsCode), .dataToggle(dataToggle), .pktAccept(pktAccept));

// *** testbench/uoec_host_model.sv ***
// Host side model: one OUT data packet per bench request
module uoec_host_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Bench request
    input wire logic sendReq,
    input wire logic [9:0] sendCount,
    input wire logic sendCrc,
    // Packet receiver outputs
    output logic rxPacketDone,
    output logic [9:0] rxByteCount,
    output logic rxCrcError
);
    timeunit 1ns;
    timeprecision 1ps;

    // Count and error mean something only with the pulse, so they churn between packets
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rxPacketDone <= 1'b0;
            rxByteCount <= 10'h000;
            rxCrcError <= 1'b0;
        end else begin
            rxPacketDone <= sendReq;
            rxByteCount <= sendReq ? sendCount : ~rxByteCount;
            rxCrcError <= sendReq ? sendCrc : ~rxCrcError;
        end
    end
endmodule : uoec_host_model

// *** testbench/usb_out_endpoint_control_bench.sv ***
// Self-checking bench for the OUT endpoint control block
module usb_out_endpoint_control_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] ACL = 8'h50, ACH = 8'h54, ANL = 8'h58, ANH = 8'h5C, AIS = 8'h60, AIM = 8'h64;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic avs_read = 1'b0, avs_write = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, irq, dataToggle, rxPacketDone, rxCrcError, t;
    logic sendReq = 1'b0, sendCrc = 1'b0;
    logic [9:0] sendCount = 10'h000;
    logic [9:0] rxByteCount, c, d;
    logic [7:0] regs [6] = '{ACL, ACH, ANH, AIS, AIM, 8'h80};
    int mismatches = 0, nChecks = 0;
    int seed = 32'hF060557A;

    always #5 sys_clk = ~sys_clk;

    // Byte enables stay on; lane refusal is untested
    uoec_top i_dut (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rxPacketDone(rxPacketDone),
        .rxByteCount(rxByteCount), .rxCrcError(rxCrcError), .hsValid(), .hsCode(),
        .dataToggle(dataToggle), .pktAccept(), .irq(irq));
    uoec_host_model i_host (.sys_clk(sys_clk), .rst(rst), .sendReq(sendReq), .sendCount(sendCount),
        .sendCrc(sendCrc), .rxPacketDone(rxPacketDone), .rxByteCount(rxByteCount), .rxCrcError(rxCrcError));

    // ***************************************************************
    // Helpers
    // ***************************************************************
    function automatic logic [7:0] hiOf(input logic [9:0] n);
        return {6'h00, n[9:8]};
    endfunction : hiOf

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // One bus cycle; on a read d is the expected byte. Idle edges let flush and release settle
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d);
        avs_address <= a;
        avs_writedata <= {24'h000000, d};
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        if (!wr) check(avs_readdata, {24'h000000, d});
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask : xfer

    task automatic send(input logic [9:0] n, input logic bad);
        sendCount <= n;
        sendCrc <= bad;
        sendReq <= 1'b1;
        @(posedge sys_clk);
        sendReq <= 1'b0;
        repeat (5) @(posedge sys_clk);
    endtask : send

    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", nChecks, mismatches);
        if (mismatches == 0 && nChecks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict

    // Cut a hang short; a clean run is far shorter
    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        print_verdict();
    end

    initial begin
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        foreach (regs[i]) xfer(1'b0, regs[i], 8'h00);
        xfer(1'b1, ACH, 8'hFF);
        xfer(1'b0, ACH, 8'hC0);
        xfer(1'b1, ACH, 8'h80);
        // Random packet pairs: fill, refuse, release, flush
        repeat (3) begin
            c = 10'($random(seed));
            d = 10'($random(seed));
            t = dataToggle;
            send(c, 1'b0);
            check(dataToggle, !t);
            xfer(1'b0, ACL, 8'h01);
            send(d, 1'b0);
            send(~c, 1'b0);
            xfer(1'b0, ACL, 8'h03);
            xfer(1'b0, ANL, c[7:0]);
            xfer(1'b0, ANH, hiOf(c));
            xfer(1'b1, ACL, 8'h00);
            xfer(1'b0, ACL, 8'h01);
            xfer(1'b0, ANL, d[7:0]);
            xfer(1'b1, ACL, 8'h11);
            xfer(1'b0, ACL, 8'h00);
        end
        // Interrupt stays low while masked, follows the mask, drops on clear
        check(irq, 1'b0);
        xfer(1'b0, AIS, 8'h01);
        xfer(1'b1, AIM, 8'h07);
        check(irq, 1'b1);
        xfer(1'b1, AIS, 8'h07);
        check(irq, 1'b0);
        // Stall in bulk mode, then ending it
        xfer(1'b1, ACH, 8'h00);
        send(~c, 1'b1);
        xfer(1'b1, ACL, 8'h20);
        send(c, 1'b0);
        xfer(1'b0, ACL, 8'h60);
        xfer(1'b0, AIS, 8'h02);
        xfer(1'b1, ACL, 8'h00);
        send(c, 1'b0);
        xfer(1'b0, ACL, 8'h03);
        // Isochronous: stall ignored, bad packet kept, overrun
        xfer(1'b1, ACH, 8'h40);
        xfer(1'b1, ACL, 8'h20);
        xfer(1'b1, AIS, 8'h07);
        send(d, 1'b1);
        xfer(1'b0, ACL, 8'h2B);
        send(d, 1'b0);
        xfer(1'b0, ACL, 8'h2F);
        xfer(1'b0, AIS, 8'h05);
        xfer(1'b1, ACL, 8'h04);
        xfer(1'b0, ACL, 8'h04);
        xfer(1'b1, ACL, 8'h00);
        xfer(1'b0, ACL, 8'h00);
        // Toggle clear from a known one
        xfer(1'b1, ACH, 8'h00);
        send(c, 1'b0);
        xfer(1'b1, ACL, 8'h00);
        if (dataToggle !== 1'b1) send(c, 1'b0);
        xfer(1'b1, ACL, 8'h80);
        check(dataToggle, 1'b0);
        xfer(1'b0, ACL, 8'h00);
        print_verdict();
    end
endmodule : usb_out_endpoint_control_bench
